// ---- verilog/usb_host_params.svh ----
`ifndef USB_HOST_PARAMS_SVH
`define USB_HOST_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_FUNC_ADDR 8'h00
`define OFS_TOKEN_CMD 8'h04
`define OFS_FRAME_THR 8'h08
`define OFS_CONTROL 8'h0c
`define OFS_STATUS 8'h10

// ==========================================================================
// Field positions
`define LOW_SPEED_BIT 7
`define TOKEN_BUSY_BIT 0
`define HOST_MODE_BIT 1
`define SOF_EN_BIT 0

// ==========================================================================
// Token kind codes
`define KIND_SETUP 4'hd
`define KIND_IN 4'h9
`define KIND_OUT 4'h1

// ==========================================================================
// Reset values
`define RST_BYTE 8'h00

// ==========================================================================
// Timing: 1 ms frame at 20 MHz, 12 Mb/s full speed bit time
`define CLK_HZ 20000000
`define FRAME_US 1000
`define FRAME_CYCLES ((`CLK_HZ / 1000000) * `FRAME_US)
`define FS_BIT_HZ 12000000
`define LS_BIT_HZ 1500000
`define TOKEN_CYCLES 16'd2000

`endif

// ---- verilog/usb_host_pkg.sv ----
package usb_host_pkg;

   // =======================================================================
   // Transaction kinds
   typedef enum logic [1:0] {
      xact_setup,
      xact_in,
      xact_out,
      xact_sof
   } xact_kind_t;

   // Engine states
   typedef enum logic [1:0] {
      st_idle,
      st_wait_frame,
      st_run
   } eng_state_t;

   // Request issued toward the USB link engine
   typedef struct packed {
      logic start;
      xact_kind_t kind;
      logic [6:0] address;
      logic [3:0] endpoint;
      logic low_speed;
   } link_req_t;

   // Whole state of the block
   typedef struct packed {
      logic [7:0] func_addr;
      logic [7:0] token_cmd;
      logic [7:0] frame_thr;
      logic sof_en;
      logic host_mode;
      eng_state_t state;
      logic token_busy;
      logic [15:0] frame_cnt;
      logic [15:0] run_cnt;
      link_req_t req;
      logic awv;
      logic [7:0] awaddr;
      logic wv;
      logic [7:0] wdata;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

endpackage : usb_host_pkg

// ---- verilog/usb_host_token_address_regs.sv ----
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "usb_host_params.svh"

// Behaviour
// [RULE_01] Upper byte of each register reads zero and ignores writes.
// [RULE_02] Low-speed select one runs transactions at low speed, else full.
// [RULE_03] Low-speed select reads zero and is ignored outside host mode.
// [RULE_04] A seven-bit function address addresses every transaction.
// [RULE_05] Token command holds kind in bits 7-4, endpoint in bits 3-0.
// [RULE_06] Kind 1101 is SETUP, 1001 is IN and 0001 is OUT.
// [RULE_07] Software writes no reserved token kind.
// [RULE_08] Software names only endpoints that exist on the peripheral.
// [RULE_09] The threshold is ten plus the largest packet size in bytes.
// [RULE_10] Token busy is one while a token executes, zero otherwise.
// [RULE_11] With frame markers enabled in host mode, one goes out each ms.
// [RULE_12] No token starts when frame time left is below the threshold; the code checks this only while sof_en is set.
// [RULE_13] A token command write while idle starts that transaction.
module usb_host_token_address_regs (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Link engine side
   output usb_host_pkg::link_req_t link_req,
   input wire logic link_done,
   // Status out
   output logic token_in_progress
);

   // =======================================================================
   // State
   usb_host_pkg::state_t s_reg;
   usb_host_pkg::state_t s_next;

   logic [7:0] addr_view;
   logic [15:0] left_bits;
   logic [15:0] thr_cycles;
   logic wr_go;
   logic [7:0] wa;
   logic [7:0] wd;
   logic kind_ok;
   usb_host_pkg::xact_kind_t kind_dec;

   // Low-speed bit hidden outside host mode
   assign addr_view = {s_reg.func_addr[`LOW_SPEED_BIT] & s_reg.host_mode,
      s_reg.func_addr[6:0]}; // [RULE_03]

   // Frame time left in full-speed bit times
   // Product reaches about 2.4e11, so it is formed in 64 bits
   assign left_bits = 16'((64'(`FRAME_CYCLES) - 64'(s_reg.frame_cnt))
      * 64'(`FS_BIT_HZ) / 64'(`CLK_HZ));
   assign thr_cycles = {8'h00, s_reg.frame_thr}; // [RULE_09]

   // Next state
   always_comb begin
      s_next = s_reg;
      wr_go = 1'b0;
      wa = s_reg.awv ? s_reg.awaddr : s_axi_awaddr;
      wd = s_reg.wv ? s_reg.wdata : s_axi_wdata[7:0]; // [RULE_01]
      kind_ok = 1'b1;
      kind_dec = usb_host_pkg::xact_out;
      // Link request is a one-cycle pulse
      s_next.req.start = 1'b0;
      // Write channel capture
      if (s_axi_awvalid && s_axi_awready) begin
         s_next.awv = 1'b1;
         s_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_next.wv = 1'b1;
         s_next.wdata = s_axi_wdata[7:0];
      end
      // Commit once both halves of the write are in
      if ((s_reg.awv || (s_axi_awvalid && s_axi_awready)) &&
          (s_reg.wv || (s_axi_wvalid && s_axi_wready)) && !s_reg.bvalid) begin
         wr_go = 1'b1;
         s_next.awv = 1'b0;
         s_next.wv = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = 2'h0;
      end
      // Write response leaves once taken
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      // Register writes, low byte lane only
      if (wr_go && (s_reg.wv || s_axi_wstrb[0])) begin
         unique case (wa)
            `OFS_FUNC_ADDR: s_next.func_addr = wd; // [RULE_04]
            `OFS_TOKEN_CMD: begin
               if (!s_reg.token_busy) begin
                  s_next.token_cmd = wd; // [RULE_05]
                  s_next.token_busy = 1'b1; // [RULE_13]
                  s_next.state = usb_host_pkg::st_wait_frame;
               end
            end
            `OFS_FRAME_THR: s_next.frame_thr = wd;
            `OFS_CONTROL: begin
               s_next.sof_en = wd[`SOF_EN_BIT];
               s_next.host_mode = wd[`HOST_MODE_BIT];
            end
            default: s_next.bresp = 2'h2;
         endcase
      end else if (wr_go) begin
         unique case (wa)
            `OFS_FUNC_ADDR, `OFS_TOKEN_CMD, `OFS_FRAME_THR,
            `OFS_CONTROL: s_next.bresp = 2'h0;
            default: s_next.bresp = 2'h2;
         endcase
      end
      // Reads
      if (s_axi_arvalid && s_axi_arready) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = 2'h0;
         unique case (s_axi_araddr)
            `OFS_FUNC_ADDR: s_next.rdata = {24'h0, addr_view}; // [RULE_01]
            `OFS_TOKEN_CMD: s_next.rdata = {24'h0, s_reg.token_cmd};
            `OFS_FRAME_THR: s_next.rdata = {24'h0, s_reg.frame_thr};
            `OFS_CONTROL: s_next.rdata = {30'h0, s_reg.host_mode, s_reg.sof_en};
            `OFS_STATUS: s_next.rdata = {31'h0, s_reg.token_busy}; // [RULE_10]
            default: begin
               s_next.rdata = 32'h0;
               s_next.rresp = 2'h2;
            end
         endcase
      end else if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
      // Token kind decode
      unique case (s_reg.token_cmd[7:4])
         `KIND_SETUP: kind_dec = usb_host_pkg::xact_setup; // [RULE_06]
         `KIND_IN: kind_dec = usb_host_pkg::xact_in; // [RULE_06]
         `KIND_OUT: kind_dec = usb_host_pkg::xact_out; // [RULE_06]
         default: kind_ok = 1'b0; // [RULE_07]
      endcase
      // Frame timer and frame marker
      if (s_reg.frame_cnt == 16'(`FRAME_CYCLES - 1)) begin
         s_next.frame_cnt = 16'h0;
         if (s_reg.sof_en && s_reg.host_mode) begin
            s_next.req.start = 1'b1; // [RULE_11]
            s_next.req.kind = usb_host_pkg::xact_sof;
         end
      end else begin
         s_next.frame_cnt = s_reg.frame_cnt + 16'h1;
      end
      // Token engine
      unique case (s_reg.state)
         usb_host_pkg::st_idle: ;
         usb_host_pkg::st_wait_frame: begin
            if (!kind_ok) begin
               s_next.state = usb_host_pkg::st_idle;
               s_next.token_busy = 1'b0;
            end else if (!s_next.req.start &&
                  (left_bits >= thr_cycles || !s_reg.sof_en)) begin // [RULE_12]
               s_next.req.start = 1'b1; // [RULE_13]
               s_next.req.kind = kind_dec;
               s_next.req.address = s_reg.func_addr[6:0]; // [RULE_04]
               s_next.req.endpoint = s_reg.token_cmd[3:0]; // [RULE_08]
               s_next.req.low_speed = addr_view[`LOW_SPEED_BIT]; // [RULE_02]
               s_next.run_cnt = 16'h0;
               s_next.state = usb_host_pkg::st_run;
            end
         end
         usb_host_pkg::st_run: begin
            s_next.run_cnt = s_reg.run_cnt + 16'h1;
            if (link_done || s_reg.run_cnt == `TOKEN_CYCLES) begin
               s_next.state = usb_host_pkg::st_idle;
               s_next.token_busy = 1'b0; // [RULE_10]
            end
         end
         // Unused fourth code falls back to idle
         default: begin
            s_next.state = usb_host_pkg::st_idle;
            s_next.token_busy = 1'b0;
         end
      endcase
   end

   // Register the state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from flip-flops, except the three readies, gated from awv, wv, rvalid and bvalid
   assign s_axi_awready = !s_reg.awv && !s_reg.bvalid;
   assign s_axi_wready = !s_reg.wv && !s_reg.bvalid;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = !s_reg.rvalid;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;
   assign link_req = s_reg.req;
   assign token_in_progress = s_reg.token_busy;

endmodule : usb_host_token_address_regs

// ---- tb/usb_regs_checker.sv ----
`timescale 1ns/1ps
module usb_regs_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   // Link side
   input wire usb_host_pkg::link_req_t link_req,
   input wire logic token_in_progress
);
   logic wr_ok, tok_go, legal;
   logic [7:0] adr_q, ctl_q, tok_q;
   logic [1:0] kind_exp;
   // Decoded bus and link events
   assign wr_ok = s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready;
   assign tok_go = link_req.start && link_req.kind != usb_host_pkg::xact_sof;
   assign legal = s_axi_wdata[7:4] inside {4'hd, 4'h9, 4'h1};
   assign kind_exp = tok_q[7:4] == 4'hd ? 2'h0 :
      tok_q[7:4] == 4'h9 ? 2'h1 : 2'h2;
   // Shadow copies of written registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         adr_q <= 8'h00;
         ctl_q <= 8'h00;
         tok_q <= 8'h00;
      end else if (wr_ok) begin
         if (s_axi_awaddr == 8'h00) adr_q <= s_axi_wdata[7:0];
         if (s_axi_awaddr == 8'h0c) ctl_q <= s_axi_wdata[7:0];
         if (s_axi_awaddr == 8'h04 && !token_in_progress)
            tok_q <= s_axi_wdata[7:0];
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_write_busy: assert property (
      wr_ok && s_axi_awaddr == 8'h04 && legal && !token_in_progress
      |=> token_in_progress) else $error("token write did not start");
   a_busy_on: assert property (tok_go |-> token_in_progress)
      else $error("token issued while not busy");
   a_addr_used: assert property (
      tok_go |-> link_req.address == adr_q[6:0])
      else $error("wrong function address");
   a_speed_used: assert property (
      tok_go |-> link_req.low_speed == (adr_q[7] && ctl_q[1]))
      else $error("wrong speed select");
   a_ep_used: assert property (
      tok_go |-> link_req.endpoint == tok_q[3:0])
      else $error("wrong endpoint");
   a_kind_code: assert property (
      tok_go |-> link_req.kind == kind_exp) else $error("wrong kind");
   a_rd_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   c_token: cover property (tok_go);
   c_marker: cover property (link_req.start && !tok_go);
   c_read: cover property (s_axi_rvalid);
endmodule : usb_regs_checker

bind usb_host_token_address_regs usb_regs_checker chk_u (.*);

// ---- tb/usb_link_model.sv ----
`timescale 1ns/1ps
module usb_link_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Request and answer
   input wire usb_host_pkg::link_req_t link_req,
   input wire logic slow,
   output logic link_done
);
   logic [4:0] cnt;
   initial link_done = 1'b0;
   // Finish each request after a short or long delay
   always @(posedge aclk) begin
      link_done <= aresetn && cnt == 5'h01;
      if (!aresetn) cnt <= 5'h00;
      else if (link_req.start) cnt <= slow ? 5'h14 : 5'h02;
      else if (cnt != 5'h00) cnt <= cnt - 5'h01;
   end
endmodule : usb_link_model

// ---- tb/usb_host_token_address_regs_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   err_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module usb_host_token_address_regs_tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, link_done;
   logic token_in_progress, slow, ta, tw, tr;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   logic [3:0] s_axi_wstrb;
   logic [3:0] kinds [3] = '{4'hd, 4'h9, 4'h1};
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   usb_host_pkg::link_req_t link_req, seen;
   int err_count, samples_checked, cyc, n_tok, tok_cyc;
   int sof_t[$];
   usb_host_token_address_regs dut_u (.*);
   usb_link_model link_u (.*);
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // Hang guard and request monitor
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         report_and_stop();
      end
   end
   always @(negedge aclk) begin
      if (link_req.start && link_req.kind == usb_host_pkg::xact_sof)
         sof_t.push_back(cyc);
      else if (link_req.start) begin
         seen = link_req;
         tok_cyc = cyc;
         n_tok++;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      do begin
         @(negedge aclk);
         {ta, tw, tr, rsp} = {s_axi_awready, s_axi_wready, s_axi_bvalid,
            s_axi_bresp};
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tr);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         {ta, tr, rd_v, rsp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata,
            s_axi_rresp};
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tr);
      `CHK("rdata", e, rd_v)
   endtask : rc
   task automatic wait_idle();
      // Sampled away from the edge that moves it
      do @(negedge aclk); while (token_in_progress !== 1'b0);
      @(posedge aclk);
   endtask : wait_idle
   task automatic report_and_stop();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   initial begin
      // Response readies stay high, so each answer is taken when seen
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h1;
      {s_axi_arvalid, s_axi_rready, slow} = 3'h2;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'h1;
      {err_count, samples_checked, cyc, n_tok} = 128'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 3; i++) rc(8'(4 * i), 32'h0);
      // Speed bit hidden outside host mode, upper bytes dropped
      wr(8'h00, 32'hffff_ff85);
      rc(8'h00, 32'h0000_0005);
      wr(8'h0c, 32'h0000_0002);
      wr(8'h00, 32'hffff_ff85);
      rc(8'h00, 32'h0000_0085);
      wr(8'h08, 32'hffff_ff4a);
      rc(8'h08, 32'h0000_004a);
      // Each token kind, second write lands while busy
      slow <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         wr(8'h04, {24'h0, kinds[k], 4'(k + 3)});
         wr(8'h04, 32'h0000_001f);
         rc(8'h10, 32'h1);
         wait_idle();
         `CHK("kind", 2'(k), seen.kind)
         `CHK("endpoint", 4'(k + 3), seen.endpoint)
         `CHK("address", 7'h05, seen.address)
         `CHK("speed", 1'b1, seen.low_speed)
         rc(8'h04, {24'h0, kinds[k], 4'(k + 3)});
      end
      `CHK("tokens", 3, n_tok)
      // Full speed token
      slow <= 1'b0;
      wr(8'h00, 32'h0000_002a);
      wr(8'h04, 32'h0000_0012);
      wait_idle();
      rc(8'h10, 32'h0);
      `CHK("fs address", 7'h2a, seen.address)
      `CHK("fs speed", 1'b0, seen.low_speed)
      // Unmapped place
      wr(8'h14, 32'h0000_00ff);
      `CHK("bresp", 2'h2, rsp)
      rc(8'h14, 32'h0);
      `CHK("rresp", 2'h2, rsp)
      // Frame markers one frame apart
      wr(8'h0c, 32'h0000_0003);
      while (sof_t.size() < 1) @(posedge aclk);
      // Token written inside the guard window waits for the marker
      while (cyc < sof_t[0] + 19950) @(posedge aclk);
      wr(8'h04, 32'h0000_0013);
      while (sof_t.size() < 2) @(posedge aclk);
      wait_idle();
      `CHK("after marker", 1'b1, tok_cyc > sof_t[1])
      `CHK("frame gap", 20000, sof_t[1] - sof_t[0])
      report_and_stop();
   end
endmodule : usb_host_token_address_regs_tb_top
